/* File: oscd_decode.sv */
// Operation
// - Code-protect bit 0 enables program memory protection; 1 disables it.
// - Word 1 bit 13 high enables the fail-safe clock monitor.
// - Word 1 bit 11 low blocks software oscillator and divider writes.
// - Word 1 bit 10 low holds the display charge pump off.
// - Word 1 bit 9 high makes battery pin plain I/O, no backup.
// - Bit 8 low drives clock/4 out only in external-clock or off modes.
// - Bits 6-4 load current oscillator default; code 011 reserved.
// - Codes 001 and 000 pick fast internal, 16 and 32 MHz, 1:1.
// - Bits 2-0: 111/110/101 external clock high/medium/low, else off.
// - Unimplemented bits in both words always read back as one.
// - Word 2 bit 12 high makes stack over/underflow reset the device.
// - Word 2 bit 11 high permits one pin-select lock clear/set cycle.
// - Word 2 bit 10 low forces zero-cross detect on, software ignored.
// - Bits 7-6 brown-out: always, awake only, software, or disabled.
// - Word 2 bit 5 high disables low-power brown-out detector.
// - With low-voltage programming, reset pin is master clear regardless.
// - Configuration settles from the words before software runs.
//
// Purpose: Latch and decode the two configuration words
// Assumes: Words are stable on nv_* inputs at the first enabled edge after srst falls
// Notes:   Core is held by cpu_hold until decode has completed
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module oscd_decode
  import oscd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic [13:0]   nv_osc_word,
  input  wire logic [13:0]   nv_sup_word,
  input  wire logic          nv_code_protect_n,
  input  wire logic          low_voltage_programming,
  input  wire logic          sleep_mode,
  input  wire logic          stack_fault,
  input  wire logic          sw_osc_write,
  input  wire logic [2:0]    sw_new_osc,
  input  wire logic [3:0]    sw_new_div,
  input  wire logic          pin_select_lock_wr,
  input  wire logic          pin_select_lock_val,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [13:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [13:0]        reg_rdata,
  output logic               cpu_hold,
  output oscd_clk_cfg_t      clk_cfg,
  output oscd_sup_cfg_t      sup_cfg,
  output logic [2:0]         new_oscillator_select,
  output logic [3:0]         new_divider_select,
  output logic               pin_select_lock,
  output logic               display_pump_on,
  output logic               zero_cross_on,
  output logic               brownout_on,
  output logic               stack_fault_reset,
  output logic               clock_output_on
);

  oscd_state_t   state_r;
  oscd_state_t   state_nxt;
  logic [13:0]   osc_word_r;
  logic [13:0]   sup_word_r;
  logic          prot_n_r;
  logic          low_volt_r;
  logic [2:0]    ctrl_r;
  logic          lock_used_r;
  logic          lock_cleared_r;
  oscd_clk_cfg_t clk_nxt;
  oscd_sup_cfg_t sup_nxt;
  logic [13:0]   rdata_nxt;
  logic [2:0]    pwrup_sel;
  logic [2:0]    ext_mode;
  logic          ext_clock_mode;
  logic          loading;
  logic          running;
  logic          osc_wr_ok;
  logic          lock_wr_ok;
  logic          pump_gate;
  logic          zero_gate;
  logic          bor_sw_gate;
  logic          bor_on;
  logic          ctrl_wr;

  assign loading  = (state_r == OSCD_LOAD);
  assign running  = (state_r == OSCD_RUN);

  always_comb begin
    case (state_r)
      OSCD_IDLE: state_nxt = OSCD_LOAD;
      OSCD_LOAD: state_nxt = OSCD_RUN;
      OSCD_RUN:  state_nxt = OSCD_RUN;
      default:   state_nxt = OSCD_IDLE;
    endcase
  end

  // Capture once after reset; words are then frozen
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r    <= OSCD_IDLE;
      osc_word_r <= WORD_BLANK;
      sup_word_r <= WORD_BLANK;
      prot_n_r   <= 1'b1;
      low_volt_r <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      if (state_r == OSCD_IDLE) begin
        osc_word_r <= nv_osc_word | W1_UNIMPL;
        sup_word_r <= nv_sup_word | W2_UNIMPL;
        prot_n_r   <= nv_code_protect_n;
        low_volt_r <= low_voltage_programming;
      end
    end
  end

  assign pwrup_sel      = osc_word_r[W1_PWRUP_LO +: 3];
  assign ext_mode       = osc_word_r[W1_EXTMODE_LO +: 3];
  assign ext_clock_mode = (ext_mode == EXT_HIGH) | (ext_mode == EXT_MED)
                        | (ext_mode == EXT_LOW);

  always_comb begin
    clk_nxt                           = '0;
    clk_nxt.code_protect_on           = ~prot_n_r;
    clk_nxt.failsafe_monitor_enable   = osc_word_r[W1_FAILSAFE];
    clk_nxt.clock_switch_permit       = osc_word_r[W1_SWITCH];
    clk_nxt.display_pump_permit       = osc_word_r[W1_PUMP];
    clk_nxt.battery_backup_on         = ~osc_word_r[W1_BATTERY];
    // Every mode code is external clock or off, so bit 8 always applies
    clk_nxt.clock_output_on           = ~osc_word_r[W1_CLKOUT_N];
    clk_nxt.current_oscillator_select = pwrup_sel;
    clk_nxt.oscillator_reserved       = (pwrup_sel == OSC_RESVD);
    clk_nxt.clock_divider             = DIV_1_1;
    case (pwrup_sel)
      OSC_FAST_16: clk_nxt.internal_frequency_select = FRQ_CODE_16;
      OSC_FAST_32: clk_nxt.internal_frequency_select = FRQ_CODE_32;
      default:     clk_nxt.internal_frequency_select = FRQ_CODE_0;
    endcase
    clk_nxt.external_oscillator_on    = ext_clock_mode;
    clk_nxt.external_power = ext_clock_mode ? ext_mode[1:0] : 2'h0;
  end

  always_comb begin
    sup_nxt                          = '0;
    sup_nxt.debugger_on              = ~sup_word_r[W2_DEBUG_N];
    sup_nxt.stack_fault_reset_enable = sup_word_r[W2_STACK_RST];
    sup_nxt.pin_select_one_shot_lock = sup_word_r[W2_LOCK_ONCE];
    sup_nxt.zero_cross_forced        = ~sup_word_r[W2_ZERO_DIS];
    sup_nxt.brownout_mode_select     = sup_word_r[W2_BOR_LO +: 2];
    sup_nxt.low_power_brownout_on    = ~sup_word_r[W2_LPBOR_DIS];
    sup_nxt.master_clear_active      = low_volt_r
                                     | sup_word_r[W2_MASTER_CLR];
  end

  // Published only at the load step, so they stay constant afterwards
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_cfg  <= '0;
      sup_cfg  <= '0;
      cpu_hold <= 1'b1;
    end else if (ce) begin
      if (loading) begin
        clk_cfg <= clk_nxt;
        sup_cfg <= sup_nxt;
      end
      // Held one edge past load so derived levels settle first
      cpu_hold <= ~running;
    end
  end

  // Software control register: pump, zero-cross, brown-out requests
  assign ctrl_wr = reg_wr & (reg_addr == REG_CTRL);

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= 3'h0;
    end else if (ce && ctrl_wr) begin
      ctrl_r <= reg_wdata[2:0];
    end
  end

  oscd_gate u_pump (
    .force_on   (1'b0),
    .permit     (clk_cfg.display_pump_permit),
    .sw_request (ctrl_r[0]),
    .gate_out   (pump_gate)
  );

  oscd_gate u_zero (
    .force_on   (sup_cfg.zero_cross_forced),
    .permit     (1'b1),
    .sw_request (ctrl_r[1]),
    .gate_out   (zero_gate)
  );

  oscd_gate u_bor (
    .force_on   (1'b0),
    .permit     (sup_cfg.brownout_mode_select == BOR_SW),
    .sw_request (ctrl_r[2]),
    .gate_out   (bor_sw_gate)
  );

  assign bor_on = (sup_cfg.brownout_mode_select == BOR_ALWAYS)
                | ((sup_cfg.brownout_mode_select == BOR_AWAKE) & ~sleep_mode)
                | bor_sw_gate;

  assign osc_wr_ok  = running & sw_osc_write & clk_cfg.clock_switch_permit;
  assign lock_wr_ok = running & pin_select_lock_wr
                    & ~(sup_cfg.pin_select_one_shot_lock & lock_used_r);

  // New-oscillator fields default to the power-up choice
  always_ff @(posedge clk) begin
    if (srst) begin
      new_oscillator_select <= 3'h0;
      new_divider_select    <= 4'h0;
    end else if (ce) begin
      if (loading) begin
        new_oscillator_select <= clk_nxt.current_oscillator_select;
        new_divider_select    <= clk_nxt.clock_divider;
      end else if (osc_wr_ok) begin
        new_oscillator_select <= sw_new_osc;
        new_divider_select    <= sw_new_div;
      end
    end
  end

  // One-way lock: after a clear then set, further writes are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_select_lock <= 1'b0;
      lock_cleared_r  <= 1'b0;
      lock_used_r     <= 1'b0;
    end else if (ce && lock_wr_ok) begin
      pin_select_lock <= pin_select_lock_val;
      if (!pin_select_lock_val) begin
        lock_cleared_r <= 1'b1;
      end else if (lock_cleared_r) begin
        lock_used_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      display_pump_on   <= 1'b0;
      zero_cross_on     <= 1'b0;
      brownout_on       <= 1'b0;
      stack_fault_reset <= 1'b0;
      clock_output_on   <= 1'b0;
    end else if (ce) begin
      display_pump_on   <= running & pump_gate;
      zero_cross_on     <= running & zero_gate;
      brownout_on       <= running & bor_on;
      stack_fault_reset <= running & stack_fault
                         & sup_cfg.stack_fault_reset_enable;
      clock_output_on   <= running & clk_cfg.clock_output_on;
    end
  end

  // Register read port; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      REG_OSC_WORD: rdata_nxt = osc_word_r;
      REG_SUP_WORD: rdata_nxt = sup_word_r;
      REG_CTRL:     rdata_nxt = {11'h000, ctrl_r};
      REG_STATUS:   rdata_nxt = {10'h000, lock_used_r, pin_select_lock,
                                 running, cpu_hold};
      default:      rdata_nxt = 14'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 14'h0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_nxt : 14'h0000;
    end
  end

  // Multi-step behaviours: spent one-way lock, hold then release
  sequence s_lock_spent;
    running && ce && pin_select_lock_wr
      && sup_cfg.pin_select_one_shot_lock && lock_used_r;
  endsequence

  sequence s_hold_then_free;
    cpu_hold ##1 !cpu_hold;
  endsequence

  a_unimpl_ones: assert property (@(posedge clk) disable iff (srst)
    running |-> ((osc_word_r & W1_UNIMPL) == W1_UNIMPL)
             && ((sup_word_r & W2_UNIMPL) == W2_UNIMPL))
    else $error("unimplemented bits not one");

  a_cfg_stable: assert property (@(posedge clk) disable iff (srst)
    running && $past(running) |-> $stable(clk_cfg) && $stable(sup_cfg))
    else $error("config changed while running");

  a_hold_release: assert property (@(posedge clk) disable iff (srst)
    $rose(running) && ce |-> s_hold_then_free)
    else $error("core not released after load");

  a_hold_early: assert property (@(posedge clk) disable iff (srst)
    !running |-> cpu_hold)
    else $error("core released before load");

  a_switch_block: assert property (@(posedge clk) disable iff (srst)
    running && ce && !clk_cfg.clock_switch_permit
      |=> $stable(new_oscillator_select))
    else $error("oscillator write not blocked");

  a_pump_off: assert property (@(posedge clk) disable iff (srst)
    !clk_cfg.display_pump_permit && !$past(clk_cfg.display_pump_permit)
      |-> !display_pump_on)
    else $error("pump on without permit");

  a_pump_permit: assert property (@(posedge clk) disable iff (srst)
    running && ce && clk_cfg.display_pump_permit && ctrl_r[0]
      |=> display_pump_on)
    else $error("permitted pump not on");

  a_zero_forced: assert property (@(posedge clk) disable iff (srst)
    running && ce && sup_cfg.zero_cross_forced |=> zero_cross_on)
    else $error("zero cross not forced on");

  a_bor_always: assert property (@(posedge clk) disable iff (srst)
    running && ce && sup_cfg.brownout_mode_select == BOR_ALWAYS
      |=> brownout_on)
    else $error("brown-out not always on");

  a_bor_off: assert property (@(posedge clk) disable iff (srst)
    running && ce && sup_cfg.brownout_mode_select == BOR_OFF
      |=> !brownout_on)
    else $error("brown-out on while disabled");

  a_stack_reset: assert property (@(posedge clk) disable iff (srst)
    running && ce && stack_fault && !sup_cfg.stack_fault_reset_enable
      |=> !stack_fault_reset)
    else $error("stack reset while disabled");

  a_stack_fire: assert property (@(posedge clk) disable iff (srst)
    running && ce && stack_fault && sup_cfg.stack_fault_reset_enable
      |=> stack_fault_reset)
    else $error("stack reset not raised");

  a_lock_one_shot: assert property (@(posedge clk) disable iff (srst)
    s_lock_spent |=> $stable(pin_select_lock))
    else $error("spent lock changed");

  a_clkout_follow: assert property (@(posedge clk) disable iff (srst)
    running && ce && clk_cfg.clock_output_on |=> clock_output_on)
    else $error("clock output not driven");

  a_fast_freq: assert property (@(posedge clk) disable iff (srst)
    running && clk_cfg.current_oscillator_select == OSC_FAST_32
      |-> clk_cfg.internal_frequency_select == FRQ_CODE_32)
    else $error("wrong fast frequency");

endmodule : oscd_decode
`default_nettype wire

/* File: oscd_gate.sv */
// Purpose: One gated control: forced, permitted or software driven
// Assumes: Combinational, inputs synchronous to clk
// Notes:   Used for pump, zero-cross and brown-out software gates
`timescale 1ns/100ps
`default_nettype none
module oscd_gate (
  input  wire logic force_on,
  input  wire logic permit,
  input  wire logic sw_request,
  output logic      gate_out
);
  assign gate_out = force_on | (permit & sw_request);
endmodule : oscd_gate
`default_nettype wire

/* File: oscd_pkg.sv */
// Purpose: Shared constants and types for the configuration word decoder
// Assumes: 14-bit configuration words, read-only after load
// Notes:   Register indices are word addresses on the plain register port
package oscd_pkg;

  localparam int WORD_W = 14;

  // Register indices on the plain register port
  localparam logic [3:0] REG_OSC_WORD  = 4'h0;
  localparam logic [3:0] REG_SUP_WORD  = 4'h1;
  localparam logic [3:0] REG_CTRL      = 4'h2;
  localparam logic [3:0] REG_STATUS    = 4'h3;

  // Word 1 field positions
  localparam int W1_FAILSAFE   = 13;
  localparam int W1_SWITCH     = 11;
  localparam int W1_PUMP       = 10;
  localparam int W1_BATTERY    = 9;
  localparam int W1_CLKOUT_N   = 8;
  localparam int W1_PWRUP_LO   = 4;
  localparam int W1_EXTMODE_LO = 0;

  // Word 2 field positions
  localparam int W2_DEBUG_N    = 13;
  localparam int W2_STACK_RST  = 12;
  localparam int W2_LOCK_ONCE  = 11;
  localparam int W2_ZERO_DIS   = 10;
  localparam int W2_BOR_LO     = 6;
  localparam int W2_LPBOR_DIS  = 5;
  localparam int W2_MASTER_CLR = 0;

  // Unimplemented bits read as one
  localparam logic [13:0] W1_UNIMPL = 14'h1088;
  localparam logic [13:0] W2_UNIMPL = 14'h0118;
  // Erased (blank) word value used at reset before a load
  localparam logic [13:0] WORD_BLANK = 14'h3FFF;

  // Power-up oscillator codes
  localparam logic [2:0] OSC_EXT      = 3'h7;
  localparam logic [2:0] OSC_FAST     = 3'h6;
  localparam logic [2:0] OSC_SLOW     = 3'h5;
  localparam logic [2:0] OSC_SECOND   = 3'h4;
  localparam logic [2:0] OSC_RESVD    = 3'h3;
  localparam logic [2:0] OSC_EXT_PLL  = 3'h2;
  localparam logic [2:0] OSC_FAST_16  = 3'h1;
  localparam logic [2:0] OSC_FAST_32  = 3'h0;

  // Fast internal frequency codes (MHz figures as printed)
  localparam int          FREQ_16_MHZ = 16;
  localparam int          FREQ_32_MHZ = 32;
  localparam logic [3:0]  FRQ_CODE_16 = 4'h5;
  localparam logic [3:0]  FRQ_CODE_32 = 4'h6;
  localparam logic [3:0]  FRQ_CODE_0  = 4'h0;
  localparam logic [3:0]  DIV_1_1     = 4'h0;

  // External oscillator modes
  localparam logic [2:0] EXT_HIGH = 3'h7;
  localparam logic [2:0] EXT_MED  = 3'h6;
  localparam logic [2:0] EXT_LOW  = 3'h5;

  // Brown-out modes
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_AWAKE  = 2'h2;
  localparam logic [1:0] BOR_SW     = 2'h1;
  localparam logic [1:0] BOR_OFF    = 2'h0;

  typedef enum logic [2:0] {
    OSCD_IDLE = 3'b001,
    OSCD_LOAD = 3'b010,
    OSCD_RUN  = 3'b100
  } oscd_state_t;

  typedef struct packed {
    logic       code_protect_on;
    logic       failsafe_monitor_enable;
    logic       clock_switch_permit;
    logic       display_pump_permit;
    logic       battery_backup_on;
    logic       clock_output_on;
    logic [2:0] current_oscillator_select;
    logic [3:0] internal_frequency_select;
    logic [3:0] clock_divider;
    logic       oscillator_reserved;
    logic [1:0] external_power;
    logic       external_oscillator_on;
  } oscd_clk_cfg_t;

  typedef struct packed {
    logic       debugger_on;
    logic       stack_fault_reset_enable;
    logic       pin_select_one_shot_lock;
    logic       zero_cross_forced;
    logic [1:0] brownout_mode_select;
    logic       low_power_brownout_on;
    logic       master_clear_active;
  } oscd_sup_cfg_t;

endpackage : oscd_pkg

/* File: tb_top.sv */
// Purpose: Self-checking bench for the configuration word decoder
// Assumes: Words held steady on the nv inputs across each reset release
// Notes:   Every word pattern needs its own reset, since words load once
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import oscd_pkg::*;
();

  logic          clk, srst, ce, prot_n, low_volt, sleep_mode, stack_fault;
  logic          sw_osc_write, lock_wr, lock_val, reg_wr, reg_rd;
  logic [13:0]   w1, w2, reg_wdata, reg_rdata;
  logic [2:0]    sw_new_osc, new_osc;
  logic [3:0]    sw_new_div, reg_addr, new_div;
  logic          cpu_hold, lock, pump, zc, bor, sfr, clko;
  oscd_clk_cfg_t clk_cfg;
  oscd_sup_cfg_t sup_cfg;
  int            errors, n_compared, cycles;

  oscd_decode i_dut (.clk(clk), .srst(srst), .ce(ce), .nv_osc_word(w1),
    .nv_sup_word(w2), .nv_code_protect_n(prot_n),
    .low_voltage_programming(low_volt), .sleep_mode(sleep_mode),
    .stack_fault(stack_fault), .sw_osc_write(sw_osc_write),
    .sw_new_osc(sw_new_osc), .sw_new_div(sw_new_div),
    .pin_select_lock_wr(lock_wr), .pin_select_lock_val(lock_val),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_hold(cpu_hold),
    .clk_cfg(clk_cfg), .sup_cfg(sup_cfg), .new_oscillator_select(new_osc),
    .new_divider_select(new_div), .pin_select_lock(lock),
    .display_pump_on(pump), .zero_cross_on(zc), .brownout_on(bor),
    .stack_fault_reset(sfr), .clock_output_on(clko));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic [13:0] a, b, input logic p, v);
    int k;
    @(posedge clk);
    srst <= 1'b1;
    w1 <= a;
    w2 <= b;
    prot_n <= p;
    low_volt <= v;
    repeat (3) @(posedge clk);
    #1;
    chk(cpu_hold, 1'b1);
    chk(|{clk_cfg, sup_cfg, pump, zc, bor, sfr, clko}, 1'b0);
    @(posedge clk);
    srst <= 1'b0;
    for (k = 0; k < 8 && cpu_hold !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk(cpu_hold, 1'b0);
  endtask : do_reset

  task automatic rd(input logic [3:0] a, output logic [13:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [13:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic lk(input logic v);
    @(posedge clk);
    lock_wr <= 1'b1;
    lock_val <= v;
    @(posedge clk);
    lock_wr <= 1'b0;
    settle();
  endtask : lk

  task automatic t_word1;
    logic [13:0] w, d;
    logic [2:0]  p, o;
    logic [3:0]  f, pd;
    for (int i = 0; i < 8; i++) begin
      p = 3'(i);
      w = {p[0], p[1], p[1], p[2], ~p[0], p[1] ^ p[2], p[0], p, p[2], ~p};
      do_reset(w, 14'h3FFF, p[0], 1'b0);
      o = w[6:4];
      chk(clk_cfg.code_protect_on, !p[0]);
      chk(clk_cfg.failsafe_monitor_enable, w[13]);
      chk(clk_cfg.clock_switch_permit, w[11]);
      chk(clk_cfg.display_pump_permit, w[10]);
      chk(clk_cfg.battery_backup_on, !w[9]);
      chk(clk_cfg.clock_output_on, !w[8]);
      chk(clko, !w[8]);
      chk(clk_cfg.current_oscillator_select, o);
      chk(clk_cfg.oscillator_reserved, o == OSC_RESVD);
      f = (o == OSC_FAST_16) ? FRQ_CODE_16 :
          (o == OSC_FAST_32) ? FRQ_CODE_32 : FRQ_CODE_0;
      chk(clk_cfg.internal_frequency_select, f);
      if (o <= OSC_FAST_16) chk(clk_cfg.clock_divider, DIV_1_1);
      chk(clk_cfg.external_oscillator_on, w[2:0] >= EXT_LOW);
      chk(clk_cfg.external_power, (w[2:0] >= EXT_LOW) ? w[1:0] : 2'h0);
      rd(REG_OSC_WORD, d);
      chk(d, w | W1_UNIMPL);
      p = new_osc;
      pd = new_div;
      @(posedge clk);
      sw_osc_write <= 1'b1;
      sw_new_osc <= ~3'(i);
      sw_new_div <= 4'(i + 1);
      @(posedge clk);
      sw_osc_write <= 1'b0;
      settle();
      chk(new_osc, w[11] ? 3'(~i) : p);
      chk(new_div, w[11] ? 4'(i + 1) : pd);
    end
    $display("test word1 decode done");
  endtask : t_word1

  task automatic t_word2;
    logic [13:0] w, d;
    logic [1:0]  p;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      w = {p[0], p[1], ~p[0], ^p, p[0], p[1], p, p[1], p[0], p[1], 2'h3,
           p[0]};
      do_reset(14'h3FFF, w, 1'b1, p[1]);
      chk(sup_cfg.debugger_on, !w[13]);
      chk(sup_cfg.stack_fault_reset_enable, w[12]);
      chk(sup_cfg.pin_select_one_shot_lock, w[11]);
      chk(sup_cfg.zero_cross_forced, !w[10]);
      chk(sup_cfg.brownout_mode_select, w[7:6]);
      chk(sup_cfg.low_power_brownout_on, !w[5]);
      chk(sup_cfg.master_clear_active, p[1] | w[0]);
      rd(REG_SUP_WORD, d);
      chk(d, w | W2_UNIMPL);
      @(posedge clk);
      stack_fault <= 1'b1;
      repeat (2) @(posedge clk);
      stack_fault <= 1'b0;
      #1 chk(sfr, w[12]);
      lk(1'b0);
      chk(lock, 1'b0);
      lk(1'b1);
      chk(lock, 1'b1);
      lk(1'b0);
      chk(lock, w[11]);
      rd(REG_STATUS, d);
      chk(d, {10'h000, 1'b1, w[11], 2'b10});
    end
    $display("test word2 decode done");
  endtask : t_word2

  task automatic t_gates;
    logic [1:0] p;
    logic [2:0] c;
    logic       e;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      do_reset({3'h7, p[1], 10'h3FF}, {3'h7, p[0], 2'h3, p, 6'h3F},
               1'b1, 1'b0);
      for (int k = 0; k < 16; k++) begin
        c = 3'(k >> 1);
        wr(REG_CTRL, 14'(c));
        @(posedge clk);
        sleep_mode <= k[0];
        settle();
        e = (p == BOR_ALWAYS) | ((p == BOR_AWAKE) & ~k[0]) |
            ((p == BOR_SW) & c[2]);
        chk(pump, p[1] & c[0]);
        chk(zc, !p[0] | c[1]);
        chk(bor, e);
      end
    end
    $display("test software gates done");
  endtask : t_gates

  task automatic t_static;
    logic [13:0] d;
    do_reset(14'h2A55, 14'h15AA, 1'b1, 1'b0);
    @(posedge clk);
    w1 <= 14'h1520;
    w2 <= 14'h2A00;
    prot_n <= 1'b0;
    settle();
    chk(clk_cfg.current_oscillator_select, 3'h5);
    chk(clk_cfg.code_protect_on, 1'b0);
    chk(sup_cfg.stack_fault_reset_enable, 1'b1);
    // Read-only words must shrug off writes
    wr(REG_OSC_WORD, 14'h0000);
    rd(REG_OSC_WORD, d);
    chk(d, 14'h2A55 | W1_UNIMPL);
    rd(4'hF, d);
    chk(d, 14'h0000);
    // Low clock enable must drop a control write
    @(posedge clk);
    ce <= 1'b0;
    wr(REG_CTRL, 14'h0007);
    ce <= 1'b1;
    rd(REG_CTRL, d);
    chk(d, 14'h0000);
    $display("test static settings done");
  endtask : t_static

  initial begin
    {srst, ce, prot_n, low_volt, sleep_mode, stack_fault} = 6'h38;
    {sw_osc_write, lock_wr, lock_val, reg_wr, reg_rd} = 5'h00;
    {w1, w2, reg_wdata} = {3{14'h3FFF}};
    {sw_new_osc, sw_new_div, reg_addr} = 11'h000;
    errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_word1();
    t_word2();
    t_gates();
    t_static();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
